/* File: rtl/inventory_id_defines.vh */
// Command codes, byte counts, status bit positions for the inventory store.
// Assumes inclusion by the inventory store modules only.
`ifndef INVENTORY_ID_DEFINES_VH
`define INVENTORY_ID_DEFINES_VH

// ****************************************
// Command codes
// ****************************************
`define CMD_MODEL 8'h9a
`define CMD_REVISION 8'h9b
`define CMD_SERIAL 8'h9e
`define CMD_CHIP_ID 8'had
`define CMD_MAKER 8'h99

// ****************************************
// Block sizes
// ****************************************
`define STORE_BYTES 4'h3
`define CHIP_ID_BYTES 4'h6

// ****************************************
// Status bit positions
// ****************************************
`define STATUS_BYTE_CML_BIT 1
`define STATUS_CML_IVC_BIT 7

`endif

/* File: rtl/inventory_checksum.v */
// Running checksum over the three-byte user stores.
// Assumes the stores are stable registers on the same clock.
`timescale 1ns/1ps
module inventory_checksum (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Store contents
  input wire [95:0] store_data_in,
  // Result
  output reg [7:0] checksum_out
);
  integer i;
  reg [7:0] next_sum;

  always @* begin
    next_sum = 8'h00;
    for (i = 0; i < 12; i = i + 1) begin
      next_sum = next_sum + store_data_in[i*8 +: 8];
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      checksum_out <= 8'h00;
    end else begin
      checksum_out <= next_sum;
    end
  end
endmodule // inventory_checksum

/* File: rtl/pmbus_inventory_id_store.v */
// Inventory and identification command bank behind a PMBus command port.
// Assumes a transaction decoder upstream delivers command, byte strobes
// and end of transaction, all on clk_in; NVM values load at reset release.
//
// Summary of operation
// - Maker info is 24-bit read/write, NVM reset.
// - Model at 9Ah, three bytes, block access.
// - All 24 model bits read/write, NVM reset.
// - Revision at 9Bh, three-byte block read/write.
// - Serial at 9Eh, three-byte block read/write.
// - Serial contributes to the NVM checksum.
// - Chip identifier at ADh, six bytes, read only.
// - Identifier byte 0 in bits 7:0, upward.
// - Write to read-only command sets status CML.
// - Unknown command sets no status bit; only the read-only write sets CML bit 7.
// - Only a write to the read-only command raises the alert line.
`timescale 1ns/1ps
`include "inventory_id_defines.vh"
module pmbus_inventory_id_store #(
  // Arbitrary neutral identity value
  parameter [47:0] CHIP_ID = 48'h00_00_00_00_00_01
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // NVM restore values
  input wire [23:0] nvm_maker_in,
  input wire [23:0] nvm_model_in,
  input wire [23:0] nvm_revision_in,
  input wire [23:0] nvm_serial_in,
  // Command port from the transaction decoder
  input wire cmd_valid_in,
  input wire [7:0] cmd_code_in,
  input wire wr_byte_valid_in,
  input wire [7:0] wr_byte_in,
  input wire rd_byte_req_in,
  input wire xfer_end_in,
  // Fault clear from the status handler
  input wire clear_faults_in,
  // Answers
  output wire cmd_known_out,
  output reg [7:0] rd_byte_out,
  output reg rd_byte_valid_out,
  output reg [7:0] status_byte_out,
  output reg [7:0] status_cml_out,
  output reg alert_n_out,
  output wire [7:0] nvm_checksum_out,
  output wire [23:0] maker_out,
  output wire [23:0] model_out,
  output wire [23:0] revision_out,
  output wire [23:0] serial_out
);

  reg [23:0] maker_info_store;
  reg [23:0] model_info_store;
  reg [23:0] revision_info_store;
  reg [23:0] serial_number_store;
  reg [7:0] cur_cmd;
  reg [3:0] byte_idx;
  reg [23:0] shadow;
  reg loaded;
  reg write_bad;

  // ****************************************
  // Decode helpers
  // ****************************************
  function is_rw_store;
    input [7:0] code;
    begin
      is_rw_store = (code == `CMD_MODEL) || (code == `CMD_REVISION) ||
        (code == `CMD_SERIAL) || (code == `CMD_MAKER);
    end
  endfunction

  function [7:0] block_count;
    input [7:0] code;
    begin
      if (code == `CMD_CHIP_ID) begin
        block_count = {4'h0, `CHIP_ID_BYTES};
      end else if (is_rw_store(code)) begin
        block_count = {4'h0, `STORE_BYTES};
      end else begin
        block_count = 8'h00;
      end
    end
  endfunction

  function [47:0] read_image;
    input [7:0] code;
    input [23:0] mk, md, rv, sn;
    begin
      case (code)
        `CMD_MAKER: read_image = {24'h000000, mk};
        `CMD_MODEL: read_image = {24'h000000, md};
        `CMD_REVISION: read_image = {24'h000000, rv};
        `CMD_SERIAL: read_image = {24'h000000, sn};
        `CMD_CHIP_ID: read_image = CHIP_ID;
        default: read_image = 48'h000000000000;
      endcase
    end
  endfunction

  assign cmd_known_out = (cmd_code_in == `CMD_CHIP_ID) ||
    is_rw_store(cmd_code_in);
  assign maker_out = maker_info_store;
  assign model_out = model_info_store;
  assign revision_out = revision_info_store;
  assign serial_out = serial_number_store;

  wire [47:0] image = read_image(cur_cmd, maker_info_store,
    model_info_store, revision_info_store, serial_number_store);
  // Command strobe outranks a write byte in the same cycle
  wire wr_to_ro = wr_byte_valid_in && !cmd_valid_in &&
    (cur_cmd == `CMD_CHIP_ID);
  wire ivc_event = wr_to_ro && !write_bad;

  // ****************************************
  // Transaction tracking and stores
  // ****************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      cur_cmd <= 8'h00;
      byte_idx <= 4'h0;
      shadow <= 24'h000000;
      write_bad <= 1'b0;
      rd_byte_out <= 8'h00;
      rd_byte_valid_out <= 1'b0;
      loaded <= 1'b0;
      maker_info_store <= 24'h000000;
      model_info_store <= 24'h000000;
      revision_info_store <= 24'h000000;
      serial_number_store <= 24'h000000;
    end else begin
      rd_byte_valid_out <= 1'b0;
      // NVM restore right after reset release
      if (!loaded) begin
        loaded <= 1'b1;
        maker_info_store <= nvm_maker_in;
        model_info_store <= nvm_model_in;
        revision_info_store <= nvm_revision_in;
        serial_number_store <= nvm_serial_in;
      end
      if (cmd_valid_in) begin
        cur_cmd <= cmd_code_in;
        byte_idx <= 4'h0;
        write_bad <= 1'b0;
      end else if (wr_byte_valid_in) begin
        // Byte 0 is the count; data bytes follow LSB first
        // Index saturates so an overlong block never wraps into a commit
        if (byte_idx != 4'hf) begin
          byte_idx <= byte_idx + 4'h1;
        end
        if (wr_to_ro) begin
          write_bad <= 1'b1;
        end else if (byte_idx == 4'h0) begin
          write_bad <= (wr_byte_in != `STORE_BYTES) ||
            !is_rw_store(cur_cmd);
        end else if (byte_idx <= `STORE_BYTES) begin
          shadow[(byte_idx - 4'h1)*8 +: 8] <= wr_byte_in;
        end
      end else if (rd_byte_req_in) begin
        if (byte_idx != 4'hf) begin
          byte_idx <= byte_idx + 4'h1;
        end
        rd_byte_valid_out <= 1'b1;
        if (byte_idx == 4'h0) begin
          rd_byte_out <= block_count(cur_cmd);
        end else if (byte_idx <= `CHIP_ID_BYTES) begin
          rd_byte_out <= image[(byte_idx - 4'h1)*8 +: 8];
        end else begin
          rd_byte_out <= 8'hff;
        end
      end
      // Commit any store-command transfer ending at byte_idx 4 without write_bad, a count-plus-three-byte read included; other lengths are dropped
      if (xfer_end_in && !write_bad && byte_idx == 4'h4 &&
          is_rw_store(cur_cmd)) begin
        case (cur_cmd)
          `CMD_MAKER: maker_info_store <= shadow;
          `CMD_MODEL: model_info_store <= shadow;
          `CMD_REVISION: revision_info_store <= shadow;
          `CMD_SERIAL: serial_number_store <= shadow;
          default: shadow <= shadow;
        endcase
      end
    end
  end

  // ****************************************
  // Fault status and alert
  // ****************************************
  // Set wins over clear so a fault never slips through
  // Alert is a level; only a fault clear or reset releases it
  always @(posedge clk_in) begin
    if (reset_in) begin
      status_byte_out <= 8'h00;
      status_cml_out <= 8'h00;
      alert_n_out <= 1'b1;
    end else begin
      if (ivc_event) begin
        status_byte_out[`STATUS_BYTE_CML_BIT] <= 1'b1;
        status_cml_out[`STATUS_CML_IVC_BIT] <= 1'b1;
        alert_n_out <= 1'b0;
      end else if (clear_faults_in) begin
        status_byte_out <= 8'h00;
        status_cml_out <= 8'h00;
        alert_n_out <= 1'b1;
      end
    end
  end

  // ****************************************
  // Checksum over stored data
  // ****************************************
  inventory_checksum u_checksum (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .store_data_in({serial_number_store, revision_info_store,
      model_info_store, maker_info_store}),
    .checksum_out(nvm_checksum_out)
  );

endmodule // pmbus_inventory_id_store

/* File: bench/inv_store_sva.sv */
// Checker for the inventory store command port.
// Assumes a bind onto the store top from the testbench file.
`timescale 1ns/1ps
module inv_store_sva (
  // Inputs watched
  input wire clk_in,
  input wire reset_in,
  input wire cmd_valid_in,
  input wire [7:0] cmd_code_in,
  input wire wr_byte_valid_in,
  input wire rd_byte_req_in,
  input wire xfer_end_in,
  input wire clear_faults_in,
  // Outputs watched
  input wire cmd_known_out,
  input wire [7:0] rd_byte_out,
  input wire rd_byte_valid_out,
  input wire [7:0] status_byte_out,
  input wire [7:0] status_cml_out,
  input wire alert_n_out,
  input wire [23:0] model_out
);
  // ****************************
  // Properties
  // ****************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire rd_only = rd_byte_req_in && !cmd_valid_in && !wr_byte_valid_in;
  a_read_answered: assert property (
    rd_only |=> rd_byte_valid_out)
    else $error("read not answered");
  a_no_spurious_read: assert property (
    rd_byte_valid_out |-> $past(rd_byte_req_in))
    else $error("unrequested read byte");
  a_id_count: assert property (
    cmd_valid_in && cmd_code_in == 8'had ##1 rd_only
    |=> rd_byte_out == 8'h06)
    else $error("bad identifier count");
  a_model_count: assert property (
    cmd_valid_in && cmd_code_in == 8'h9a ##1 rd_only
    |=> rd_byte_out == 8'h03)
    else $error("bad model count");
  a_cml_pair: assert property (
    $rose(status_cml_out[7]) |-> status_byte_out[1])
    else $error("cml summary not set");
  a_fault_holds: assert property (
    status_cml_out[7] && !clear_faults_in |=> status_cml_out[7])
    else $error("fault flag dropped");
  a_alert_cause: assert property (
    $fell(alert_n_out) |-> status_cml_out[7])
    else $error("alert without fault");
  a_clear_alert: assert property (
    clear_faults_in && !wr_byte_valid_in |=> alert_n_out)
    else $error("alert not cleared");
  a_model_stable: assert property (
    !xfer_end_in && !$past(reset_in) |=> $stable(model_out))
    else $error("model changed without commit");
  a_known_code: assert property (
    cmd_known_out ==
    (cmd_code_in inside {8'h99, 8'h9a, 8'h9b, 8'h9e, 8'had}))
    else $error("command decode wrong");
endmodule // inv_store_sva

/* File: bench/pmbus_host_model.sv */
// Host side of the command port: block writes and block reads.
// Assumes the store answers a read request one cycle later.
`timescale 1ns/1ps
module pmbus_host_model (
  // Clock and answers
  input wire clk_in,
  input wire [7:0] rd_byte_in,
  input wire rd_byte_valid_in,
  // Requests
  output reg cmd_valid_out = 1'b0,
  output reg [7:0] cmd_code_out = 8'h00,
  output reg wr_valid_out = 1'b0,
  output reg [7:0] wr_byte_out = 8'h00,
  output reg rd_req_out = 1'b0,
  output reg xfer_end_out = 1'b0
);
  // ****************************
  // Transactions
  // ****************************
  task automatic start(input [7:0] code);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= code;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
  endtask
  // Count byte first, then data low byte first
  task automatic write(input [7:0] code, input [7:0] cnt, input [23:0] d);
    logic [31:0] w;
    w = {d, cnt};
    start(code);
    for (int i = 0; i < 4; i++) begin
      wr_valid_out <= 1'b1;
      wr_byte_out <= w[8*i +: 8];
      @(posedge clk_in);
    end
    wr_valid_out <= 1'b0;
    xfer_end_out <= 1'b1;
    @(posedge clk_in);
    xfer_end_out <= 1'b0;
  endtask
  task automatic read(input [7:0] code, input int n,
                      output logic [55:0] got, output bit miss);
    got = '0;
    miss = 1'b0;
    start(code);
    for (int i = 0; i <= n; i++) begin
      rd_req_out <= 1'b1;
      @(posedge clk_in);
      rd_req_out <= 1'b0;
      @(negedge clk_in);
      if (rd_byte_valid_in !== 1'b1) miss = 1'b1;
      got[8*i +: 8] = rd_byte_in;
      @(posedge clk_in);
    end
  endtask
endmodule // pmbus_host_model

/* File: bench/test_pmbus_inventory_id_store.sv */
// Self-checking bench for the inventory store.
// Assumes the host model drives the command port.
`timescale 1ns/1ps
module test_pmbus_inventory_id_store;
  localparam [47:0] ID = 48'h0c0b0a030201; // Arbitrary identity value
  localparam [95:0] NVM = 96'h0102030405060708090a0b0c;
  localparam [95:0] WR = {24'h123456, 24'ha1b2c3, 24'h0f1e2d, 24'h5a6b7c};
  localparam logic [7:0] CD [4] = '{8'h99, 8'h9a, 8'h9b, 8'h9e};
  localparam logic [23:0] VL [4] = '{24'h123456, 24'ha1b2c3,
                                     24'h0f1e2d, 24'h5a6b7c};
  reg clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg clear_in = 1'b0;
  wire cv, wv, rq, xe, rv, an;
  wire [7:0] cc, wb, rb, sb, sc;
  wire [23:0] mk, md, rvs, sn;
  wire [7:0] cs;
  wire [95:0] stored = {mk, md, rvs, sn};
  int mismatches = 0;
  int tests_run = 0;
  always #2.5 clk_in = ~clk_in;
  pmbus_host_model host (.clk_in(clk_in), .rd_byte_in(rb),
    .rd_byte_valid_in(rv), .cmd_valid_out(cv), .cmd_code_out(cc),
    .wr_valid_out(wv), .wr_byte_out(wb), .rd_req_out(rq),
    .xfer_end_out(xe));
  pmbus_inventory_id_store #(.CHIP_ID(ID)) dut (.clk_in(clk_in),
    .reset_in(reset_in), .nvm_maker_in(NVM[95:72]),
    .nvm_model_in(NVM[71:48]), .nvm_revision_in(NVM[47:24]),
    .nvm_serial_in(NVM[23:0]), .cmd_valid_in(cv), .cmd_code_in(cc),
    .wr_byte_valid_in(wv), .wr_byte_in(wb), .rd_byte_req_in(rq),
    .xfer_end_in(xe), .clear_faults_in(clear_in), .cmd_known_out(),
    .rd_byte_out(rb), .rd_byte_valid_out(rv), .status_byte_out(sb),
    .status_cml_out(sc), .alert_n_out(an), .nvm_checksum_out(cs),
    .maker_out(mk), .model_out(md), .revision_out(rvs),
    .serial_out(sn));
  // ****************************
  // Scenarios
  // ****************************
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  function automatic logic [7:0] sum8(input logic [95:0] w);
    sum8 = 8'h00;
    for (int i = 0; i < 12; i++) sum8 += w[8*i +: 8];
  endfunction
  task automatic t_reset();
    chk(stored === NVM && an === 1'b1, "reset load");
  endtask
  task automatic t_rw();
    logic [55:0] got;
    bit miss;
    for (int i = 0; i < 4; i++) host.write(CD[i], 8'h03, VL[i]);
    @(posedge clk_in);
    chk(stored === WR, "store");
    for (int i = 0; i < 4; i++) begin
      host.read(CD[i], 3, got, miss);
      chk(!miss && got[31:0] === {VL[i], 8'h03}, "read");
    end
    chk(cs === sum8(WR), "sum");
    host.write(8'h9e, 8'h03, VL[3] + 24'h1);
    repeat (2) @(posedge clk_in);
    chk(sn === VL[3] + 24'h1, "serial");
    chk(cs === sum8(WR) + 8'h01, "sum");
  endtask
  task automatic t_refuse();
    host.write(8'h9a, 8'h02, 24'hffffff);
    @(posedge clk_in);
    chk(md === VL[1], "short count stored");
  endtask
  task automatic t_chip();
    logic [55:0] got;
    bit miss;
    host.read(8'had, 6, got, miss);
    chk(!miss && got === {ID, 8'h06}, "identifier");
  endtask
  task automatic t_ro();
    host.write(8'had, 8'h03, 24'h111111);
    @(negedge clk_in);
    chk(sb === 8'h02, "summary bit");
    chk(sc === 8'h80, "invalid flag");
    chk(an === 1'b0, "alert");
    @(posedge clk_in);
    clear_in <= 1'b1;
    @(posedge clk_in);
    clear_in <= 1'b0;
    @(negedge clk_in);
    chk(an === 1'b1 && sc === 8'h00, "clear");
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    $display("[ERR] %0t timeout", $time);
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_reset();
    t_rw();
    t_refuse();
    t_chip();
    t_ro();
    print_verdict();
  end
endmodule // test_pmbus_inventory_id_store
bind pmbus_inventory_id_store inv_store_sva chk_i (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in),
  .wr_byte_valid_in(wr_byte_valid_in),
  .rd_byte_req_in(rd_byte_req_in),
  .xfer_end_in(xfer_end_in),
  .clear_faults_in(clear_faults_in),
  .cmd_known_out(cmd_known_out),
  .rd_byte_out(rd_byte_out),
  .rd_byte_valid_out(rd_byte_valid_out),
  .status_byte_out(status_byte_out),
  .status_cml_out(status_cml_out),
  .alert_n_out(alert_n_out),
  .model_out(model_out)
);
